/* verilog/tlw_pkg.sv */
/*
 * constants, field layout and helpers shared by the transmit list walker.
 * assumes a 32-bit shared memory seen through a word-wide master port.
 */
package tlw_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] SREQ_OFS    = 8'h04;
  localparam logic [7:0] HEAD_OFS    = 8'h08;
  localparam logic [7:0] MSGSLOT_OFS = 8'h0c;
  localparam logic [7:0] INTQ_OFS    = 8'h10;
  localparam logic [7:0] STATUS_OFS  = 8'h14;
  localparam logic [7:0] ELEM_OFS    = 8'h18;

  // ****************************************
  // register fields and reset values
  // ****************************************
  localparam int          INHIBIT_BIT  = 0;
  localparam int          ACT_BIT      = 0;
  localparam int          JUMP_BIT     = 1;
  localparam logic        CTRL_RST     = 1'b0;
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;

  // ****************************************
  // element layout
  // ****************************************
  localparam logic [31:0] DATA_PTR_OFS = 32'h0000_0004;
  localparam logic [31:0] NEXT_PTR_OFS = 32'h0000_0008;
  localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
  localparam int          OWNER_BIT    = 31;
  localparam int          NOPOLL_BIT   = 29;
  localparam int          EOB_IRQ_BIT  = 28;
  localparam int          SIZE_W       = 14;

  // ****************************************
  // interrupt descriptor codes
  // ****************************************
  localparam logic [3:0]  INTR_ACK     = 4'h1;
  localparam logic [3:0]  INTR_EOB     = 4'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 20;
  localparam int POLL_INTERVAL_NS = 10000;
  localparam int POLL_CYCLES      = POLL_INTERVAL_NS / CLK_PERIOD_NS;

  // engine ownership, polarity depends on direction
  function automatic logic ownedByEngine(input logic [31:0] ctrl,
                                         input logic        rxSection);
    ownedByEngine = ctrl[OWNER_BIT] ^ rxSection;
  endfunction

  // interrupt descriptor word
  function automatic logic [31:0] intrWord(input logic [3:0]        kind,
                                           input logic [SIZE_W-1:0] len);
    intrWord = {kind, {(28-SIZE_W){1'b0}}, len};
  endfunction

endpackage

/* verilog/tlw_poll_timer.sv */
/*
 * poll interval timer for a host-owned element.
 * assumes start is a one-cycle pulse from the walker.
 */
`timescale 1ns/100ps
module tlw_poll_timer
  import tlw_pkg::*;
#(
  parameter int CYCLES = POLL_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic start,
  output logic      done
);

  logic [15:0] count_reg;
  logic        run_reg;

  // ****************************************
  // countdown
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= 16'h0000;
      run_reg   <= 1'b0;
    end else if (start) begin
      count_reg <= 16'(CYCLES - 1);
      run_reg   <= 1'b1;
    end else if (run_reg) begin
      if (count_reg == 16'h0000) begin
        run_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  assign done = run_reg && (count_reg == 16'h0000);

endmodule

/* verilog/tlw_byte_unpacker.sv */
/*
 * holds one fetched word and hands its bytes to the transmit stream.
 * assumes bytes leave least significant first; flush drops the word.
 */
`timescale 1ns/100ps
module tlw_byte_unpacker (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // word side
  input  wire logic       load,
  input  wire logic [31:0] word,
  input  wire logic [2:0] nBytes,
  input  wire logic       flush,
  output logic            empty,
  // byte side
  output logic [7:0]      outByte,
  output logic            outValid,
  input  wire logic       outReady
);

  logic [31:0] word_reg;
  logic [2:0]  cnt_reg;

  // ****************************************
  // shift register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      word_reg <= 32'h0000_0000;
      cnt_reg  <= 3'h0;
    end else if (load) begin
      word_reg <= word;
      cnt_reg  <= nBytes;
    end else if (outValid && outReady) begin
      word_reg <= {8'h00, word_reg[31:8]};
      cnt_reg  <= cnt_reg - 3'h1;
    end
  end

  assign empty    = (cnt_reg == 3'h0);
  assign outValid = !empty;
  assign outByte  = word_reg[7:0];

endmodule

/* verilog/tlw_walker.sv */
/*
 * transmit message list walker for one channel section.
 * assumes a word memory master port whose ack is a one-cycle pulse with
 * read data beside it, and a downstream byte stream with back-pressure.
 */
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

// Overview of operation
// RULE_01: an element is three words: control, data pointer, next pointer.
// RULE_02: host ends a list by self-link or terminator it later takes back.
// RULE_03: test ownership first; service owned element, then invert the flag.
// RULE_04: element not owned ends processing; poll it or park per its flag.
// RULE_05: host never edits an element already handed to the engine.
// RULE_06: host attaches a list before requesting activation.
// RULE_07: transmit and receive sections keep separate state and requests.
// RULE_08: every service request is answered by an acknowledge descriptor.
// RULE_09: activation abandons current position and starts a new message.
// RULE_10: activation reads head pointer, then the element it addresses.
// RULE_11: transmit flag one means engine owns; load data pointer and length.
// RULE_12: transmit flag zero means host owns; recheck until owned or request.
// RULE_13: overwrite allowed: slot gets element address; status written after.
// RULE_14: overwrite inhibited: slot gets prefetched next pointer, no status.
// RULE_15: during a message, fetch buffer data from memory into the stream.
// RULE_16: at message end write descriptors as allowed, then fetch next.
// RULE_17: receive sections use the reverse ownership polarity.
// RULE_18: host prepares head pointer and elements before activate or jump.
// RULE_19: send exactly the buffer length in bytes before advancing.
// RULE_20: poll interval is a fixed constant, leaving the bus to others.
module tlw_walker
  import tlw_pkg::*;
#(
  parameter logic RX_SECTION  = 1'b0,
  parameter int   POLL_CYCLES_P = POLL_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // memory master
  output logic             memReq,
  output logic             memWr,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  // transmit byte stream
  output logic [7:0]       txByte,
  output logic             txByteValid,
  input  wire logic        txByteReady
);

  typedef enum logic [13:0] {
    ST_IDLE    = 14'h0001,
    ST_RDHEAD  = 14'h0002,
    ST_RDCTRL  = 14'h0004,
    ST_WRSACK  = 14'h0008,
    ST_CHECK   = 14'h0010,
    ST_POLL    = 14'h0020,
    ST_PARK    = 14'h0040,
    ST_RDDPTR  = 14'h0080,
    ST_RDNEXT  = 14'h0100,
    ST_WRSLOT  = 14'h0200,
    ST_DATA    = 14'h0400,
    ST_WRSTAT  = 14'h0800,
    ST_WRINTR  = 14'h1000,
    ST_ADVANCE = 14'h2000
  } tlw_state_type;

  tlw_state_type     state_reg;
  tlw_state_type     state_next;
  logic              inhibit_reg;
  logic              actPend_reg;
  logic              jumpPend_reg;
  logic [2:0]        ackCnt_reg;
  logic [31:0]       headAddr_reg;
  logic [31:0]       slotAddr_reg;
  logic [31:0]       intqAddr_reg;
  logic [31:0]       elemAddr_reg;
  logic [31:0]       ctrl_reg;
  logic [31:0]       dataPtr_reg;
  logic [31:0]       nextPtr_reg;
  logic              havePrefetch_reg;
  logic [SIZE_W-1:0] bytesLeft_reg;
  logic [31:0]       regRdata_reg;
  logic              takeAct;
  logic              takeJump;
  logic              owned;
  logic              upkEmpty;
  logic              upkLoad;
  logic              dataAbort;
  logic              dataDone;
  logic              pollDone;
  logic [2:0]        loadBytes;

  // RULE_17 direction polarity
  assign owned    = ownedByEngine(ctrl_reg, RX_SECTION);
  assign upkLoad  = (state_reg == ST_DATA) && memAck;
  assign dataDone = (bytesLeft_reg == '0) && upkEmpty;
  assign loadBytes = (bytesLeft_reg >= SIZE_W'(4)) ? 3'h4
                                                   : bytesLeft_reg[2:0];
  // RULE_09 abandon in progress
  assign dataAbort = (state_reg == ST_DATA) && actPend_reg && !memReq;

  // requests are taken only where no memory access is outstanding
  always_comb begin
    takeAct  = 1'b0;
    takeJump = 1'b0;
    case (state_reg)
      ST_IDLE, ST_POLL, ST_PARK, ST_ADVANCE: begin
        takeAct  = actPend_reg;
        takeJump = !actPend_reg && jumpPend_reg;
      end
      ST_DATA: begin
        takeAct  = dataAbort;
      end
      default: begin
        takeAct  = 1'b0;
      end
    endcase
  end

  // ****************************************
  // register port
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      inhibit_reg  <= CTRL_RST;
      headAddr_reg <= ADDR_RST;
      slotAddr_reg <= ADDR_RST;
    end else if (regWr) begin
      if (regAddr == CTRL_OFS) begin
        inhibit_reg <= regWdata[INHIBIT_BIT];
      end
      if (regAddr == HEAD_OFS) begin
        headAddr_reg <= regWdata;
      end
      if (regAddr == MSGSLOT_OFS) begin
        slotAddr_reg <= regWdata;
      end
    end
  end

  // pending requests: a new request wins over the clear
  // RULE_07 own request flags
  always_ff @(posedge clk) begin
    if (srst) begin
      actPend_reg  <= 1'b0;
      jumpPend_reg <= 1'b0;
    end else begin
      if (takeAct) begin
        actPend_reg <= 1'b0;
      end
      if (takeJump) begin
        jumpPend_reg <= 1'b0;
      end
      if (regWr && regAddr == SREQ_OFS && regWdata[ACT_BIT]) begin
        actPend_reg <= 1'b1;
      end
      if (regWr && regAddr == SREQ_OFS && regWdata[JUMP_BIT]) begin
        jumpPend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata_reg <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        CTRL_OFS:    regRdata_reg <= {31'h0, inhibit_reg};
        SREQ_OFS:    regRdata_reg <= {30'h0, jumpPend_reg, actPend_reg};
        HEAD_OFS:    regRdata_reg <= headAddr_reg;
        MSGSLOT_OFS: regRdata_reg <= slotAddr_reg;
        INTQ_OFS:    regRdata_reg <= intqAddr_reg;
        STATUS_OFS:  regRdata_reg <= {15'h0, ackCnt_reg, state_reg};
        ELEM_OFS:    regRdata_reg <= elemAddr_reg;
        default:     regRdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      regRdata_reg <= 32'h0000_0000;
    end
  end

  assign regRdata = regRdata_reg;

  // ****************************************
  // acknowledge queue
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ackCnt_reg <= 3'h0;
    end else if ((takeAct || takeJump) &&
                 !(state_reg == ST_WRSACK && memAck)) begin
      ackCnt_reg <= ackCnt_reg + 3'h1;
    end else if (!(takeAct || takeJump) && state_reg == ST_WRSACK
                 && memAck) begin
      ackCnt_reg <= ackCnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      intqAddr_reg <= ADDR_RST;
    end else if (regWr && regAddr == INTQ_OFS) begin
      intqAddr_reg <= regWdata;
    end else if (memAck && (state_reg == ST_WRSACK ||
                            state_reg == ST_WRINTR)) begin
      intqAddr_reg <= intqAddr_reg + WORD_BYTES;
    end
  end

  // ****************************************
  // element capture
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      elemAddr_reg     <= ADDR_RST;
      ctrl_reg         <= 32'h0000_0000;
      dataPtr_reg      <= ADDR_RST;
      nextPtr_reg      <= ADDR_RST;
      havePrefetch_reg <= 1'b0;
    end else begin
      if (memAck) begin
        case (state_reg)
          // RULE_10 head then element
          ST_RDHEAD: elemAddr_reg <= memRdata;
          ST_RDCTRL: ctrl_reg     <= memRdata;
          // RULE_11 load data pointer
          ST_RDDPTR: dataPtr_reg  <= memRdata;
          ST_RDNEXT: nextPtr_reg  <= memRdata;
          // RULE_15 step buffer word
          ST_DATA:   dataPtr_reg  <= dataPtr_reg + WORD_BYTES;
          default:   ctrl_reg     <= ctrl_reg;
        endcase
      end
      if (state_reg == ST_RDNEXT && memAck) begin
        havePrefetch_reg <= inhibit_reg && !havePrefetch_reg;
      end
      if (state_reg == ST_ADVANCE && !takeAct && !takeJump) begin
        elemAddr_reg     <= nextPtr_reg;
        havePrefetch_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // data fetch
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      bytesLeft_reg <= '0;
    end else if (state_reg == ST_RDDPTR && memAck) begin
      // RULE_11 load buffer length
      bytesLeft_reg <= ctrl_reg[SIZE_W-1:0];
    end else if (upkLoad) begin
      // RULE_19 count exact length
      bytesLeft_reg <= bytesLeft_reg - SIZE_W'(loadBytes);
    end else if (dataAbort) begin
      bytesLeft_reg <= '0;
    end
  end

  tlw_byte_unpacker u_unpack (
    .clk      (clk),
    .srst     (srst),
    .load     (upkLoad),
    .word     (memRdata),
    .nBytes   (loadBytes),
    .flush    (dataAbort),
    .empty    (upkEmpty),
    .outByte  (txByte),
    .outValid (txByteValid),
    .outReady (txByteReady)
  );

  // RULE_20 fixed poll interval
  tlw_poll_timer #(
    .CYCLES (POLL_CYCLES_P)
  ) u_poll (
    .clk   (clk),
    .srst  (srst),
    .start (state_reg == ST_CHECK && state_next == ST_POLL),
    .done  (pollDone)
  );

  // ****************************************
  // memory master outputs
  // ****************************************
  always_comb begin
    memReq   = 1'b0;
    memWr    = 1'b0;
    memAddr  = 32'h0000_0000;
    memWdata = 32'h0000_0000;
    case (state_reg)
      ST_RDHEAD: begin
        memReq  = 1'b1;
        memAddr = headAddr_reg;
      end
      // RULE_01 three-word element
      ST_RDCTRL: begin
        memReq  = 1'b1;
        memAddr = elemAddr_reg;
      end
      ST_RDDPTR: begin
        memReq  = 1'b1;
        memAddr = elemAddr_reg + DATA_PTR_OFS;
      end
      ST_RDNEXT: begin
        memReq  = 1'b1;
        memAddr = elemAddr_reg + NEXT_PTR_OFS;
      end
      // RULE_08 acknowledge descriptor
      ST_WRSACK: begin
        memReq   = 1'b1;
        memWr    = 1'b1;
        memAddr  = intqAddr_reg;
        memWdata = intrWord(INTR_ACK, '0);
      end
      // RULE_13 slot holds element
      // RULE_14 slot holds next
      ST_WRSLOT: begin
        memReq   = 1'b1;
        memWr    = 1'b1;
        memAddr  = slotAddr_reg;
        memWdata = inhibit_reg ? nextPtr_reg : elemAddr_reg;
      end
      // RULE_15 fetch buffer words
      ST_DATA: begin
        memReq  = upkEmpty && (bytesLeft_reg != '0);
        memAddr = dataPtr_reg;
      end
      // RULE_03 hand element back
      ST_WRSTAT: begin
        memReq   = 1'b1;
        memWr    = 1'b1;
        memAddr  = elemAddr_reg;
        memWdata = ctrl_reg ^ (32'h1 << OWNER_BIT);
      end
      ST_WRINTR: begin
        memReq   = 1'b1;
        memWr    = 1'b1;
        memAddr  = intqAddr_reg;
        memWdata = intrWord(INTR_EOB, ctrl_reg[SIZE_W-1:0]);
      end
      default: begin
        memReq = 1'b0;
      end
    endcase
  end

  // ****************************************
  // list walk sequence
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_POLL, ST_PARK, ST_ADVANCE: begin
        if (takeAct || takeJump) begin
          state_next = ST_RDHEAD;
        end else if (state_reg == ST_POLL && pollDone) begin
          state_next = ST_RDCTRL;
        end else if (state_reg == ST_ADVANCE) begin
          // RULE_16 fetch next element
          state_next = ST_RDCTRL;
        end
      end
      ST_RDHEAD:  if (memAck) state_next = ST_RDCTRL;
      ST_RDCTRL: begin
        if (memAck) begin
          state_next = (ackCnt_reg != 3'h0) ? ST_WRSACK : ST_CHECK;
        end
      end
      ST_WRSACK: begin
        if (memAck && ackCnt_reg == 3'h1) begin
          state_next = ST_CHECK;
        end
      end
      // RULE_03 ownership first
      // RULE_04 poll or park
      // RULE_12 host owned
      ST_CHECK: begin
        if (owned) begin
          state_next = ST_RDDPTR;
        end else if (ctrl_reg[NOPOLL_BIT]) begin
          state_next = ST_PARK;
        end else begin
          state_next = ST_POLL;
        end
      end
      ST_RDDPTR: begin
        if (memAck) begin
          state_next = inhibit_reg ? ST_RDNEXT : ST_WRSLOT;
        end
      end
      ST_RDNEXT: begin
        if (memAck) begin
          state_next = havePrefetch_reg ? ST_WRSTAT
                     : (inhibit_reg ? ST_WRSLOT : ST_WRSTAT);
        end
      end
      ST_WRSLOT:  if (memAck) state_next = ST_DATA;
      ST_DATA: begin
        if (dataAbort) begin
          state_next = ST_RDHEAD;
        end else if (dataDone) begin
          if (!inhibit_reg) begin
            state_next = ST_RDNEXT;
          end else begin
            state_next = ctrl_reg[EOB_IRQ_BIT] ? ST_WRINTR : ST_ADVANCE;
          end
        end
      end
      ST_WRSTAT: begin
        if (memAck) begin
          state_next = ctrl_reg[EOB_IRQ_BIT] ? ST_WRINTR : ST_ADVANCE;
        end
      end
      ST_WRINTR:  if (memAck) state_next = ST_ADVANCE;
      default:    state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_ELEM_LAYOUT: assert property ( // RULE_01
    state_reg == ST_RDNEXT |-> memAddr == elemAddr_reg + NEXT_PTR_OFS)
    else $error("next pointer read from wrong word");
  AST_OWNED_SERVICE: assert property ( // RULE_03
    state_reg == ST_CHECK && owned |=> state_reg == ST_RDDPTR)
    else $error("owned element not serviced");
  AST_NOT_OWNED: assert property ( // RULE_04
    state_reg == ST_CHECK && !owned && !ctrl_reg[NOPOLL_BIT]
    |=> state_reg == ST_POLL)
    else $error("host-owned element not polled");
  AST_HEAD_FIRST: assert property ( // RULE_10
    state_reg == ST_RDHEAD |-> memReq && !memWr && memAddr == headAddr_reg)
    else $error("head pointer not read");
  AST_ACT_ABANDON: assert property ( // RULE_09
    state_reg == ST_POLL && actPend_reg |=> state_reg == ST_RDHEAD)
    else $error("activation did not restart list");
  AST_SLOT_ELEM: assert property ( // RULE_13
    state_reg == ST_WRSLOT && !inhibit_reg |-> memWdata == elemAddr_reg)
    else $error("slot not given element address");
  AST_SLOT_NEXT: assert property ( // RULE_14
    state_reg == ST_WRSLOT && inhibit_reg |-> memWdata == nextPtr_reg)
    else $error("slot not given next pointer");
  AST_STATUS_FLIP: assert property ( // RULE_03
    state_reg == ST_WRSTAT |-> memWdata[OWNER_BIT] != ctrl_reg[OWNER_BIT]
                               && memAddr == elemAddr_reg)
    else $error("status write keeps ownership");
  AST_EXACT_LEN: assert property ( // RULE_19
    state_reg == ST_DATA && state_next != ST_DATA && !dataAbort
    |-> bytesLeft_reg == '0 && upkEmpty)
    else $error("message ended before buffer length");
  AST_ACK_POSTED: assert property ( // RULE_08
    state_reg == ST_WRSACK && memAck && ackCnt_reg == 3'h1
    && !takeAct |=> ackCnt_reg == 3'h0)
    else $error("acknowledge not retired");
  AST_HOST_OWNED: assert property ( // RULE_17
    state_reg == ST_CHECK && ctrl_reg[OWNER_BIT] == RX_SECTION
    |=> state_reg != ST_RDDPTR)
    else $error("host-owned element serviced");

  COV_POLL:   cover property (state_reg == ST_POLL ##1 state_reg == ST_RDCTRL);
  COV_STATUS: cover property (state_reg == ST_WRSTAT && memAck);
  COV_ACK:    cover property (state_reg == ST_WRSACK && memAck);
  COV_ABORT:  cover property (dataAbort);

endmodule

/* verif/tlw_mem_model.sv */
/* partner: shared host memory behind the walker's master port.
   assumes byte addresses below 0x400 and a latency set by the bench. */
`timescale 1ns/100ps
module tlw_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // master port
  input  wire logic        memReq,
  input  wire logic        memWr,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [3:0]  lat,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] mem [0:255];
  logic [3:0]  waitCnt = 4'h0;
  initial memAck = 1'b0;
  initial memRdata = 32'h0;
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (srst || !memReq || memAck)
      waitCnt <= 4'h0;
    else if (waitCnt != lat)
      waitCnt <= waitCnt + 4'h1;
    else begin
      memAck <= 1'b1;
      if (memWr)
        mem[memAddr[9:2]] <= memWdata;
      else
        memRdata <= mem[memAddr[9:2]];
    end
  end
endmodule

/* verif/tlw_walker_tb.sv */
/* self-checking bench for the transmit list walker.
   assumes the memory model as host and a four-cycle poll interval. */
`timescale 1ns/100ps
module tlw_walker_tb;
  import tlw_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata, memAddr, memWdata, memRdata;
  logic        memReq, memWr, memAck, txByteValid;
  logic [7:0]  txByte;
  logic        txByteReady = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [7:0]  got [$];
  int          cyc = 0;
  int          errorCnt = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  tlw_walker #(.RX_SECTION(1'b0), .POLL_CYCLES_P(4)) i_tlw_walker (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .txByte(txByte), .txByteValid(txByteValid),
    .txByteReady(txByteReady));

  tlw_mem_model i_tlw_mem_model (
    .clk(clk), .srst(srst), .memReq(memReq), .memWr(memWr),
    .memAddr(memAddr), .memWdata(memWdata), .lat(lat),
    .memAck(memAck), .memRdata(memRdata));

  // stalling sink, byte capture and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    txByteReady <= cyc[1];
    if (txByteValid && txByteReady)
      got.push_back(txByte);
    if (cyc == 20000) begin
      errorCnt++;
      endOfTest();
    end
  end

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic mw(input logic [31:0] a, d);
    i_tlw_mem_model.mem[a[9:2]] = d;
  endtask

  function automatic logic [31:0] mr(input logic [31:0] a);
    return i_tlw_mem_model.mem[a[9:2]];
  endfunction

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask

  task automatic waitState(input logic [31:0] st);
    logic [31:0] d;
    for (int i = 0; i < 400; i++) begin
      rdReg(STATUS_OFS, d);
      if (d[13:0] === st[13:0])
        break;
    end
    chk("state", st, {18'h0, d[13:0]});
  endtask

  task automatic testReset;
    logic [31:0] d;
    rdReg(STATUS_OFS, d);
    chk("idle", 32'h1, d);
    rdReg(CTRL_OFS, d);
    chk("ctrl", 32'h0, d);
    rdReg(8'h1c, d);
    chk("unmapped", 32'h0, d);
    $display("reset test done");
  endtask

  task automatic testActivate;
    logic [31:0] d;
    // list and head ready first, self link
    mw(32'h40, 32'h80);
    mw(32'h80, 32'h9000_0004);
    mw(32'h84, 32'hc0);
    mw(32'h88, 32'h80);
    mw(32'hc0, 32'h4433_2211);
    mw(32'h208, 32'h0);
    wrReg(HEAD_OFS, 32'h40);
    wrReg(MSGSLOT_OFS, 32'h20);
    wrReg(INTQ_OFS, 32'h200);
    wrReg(SREQ_OFS, 32'h1);
    waitState(32'h20);
    chk("count", 32'd4, got.size());
    chk("data", 32'h4433_2211, {got[3], got[2], got[1], got[0]});
    chk("status", 32'h1000_0004, mr(32'h80));
    chk("slot", 32'h80, mr(32'h20));
    chk("ack", 32'h1000_0000, mr(32'h200));
    chk("eob", 32'h2000_0004, mr(32'h204));
    rdReg(ELEM_OFS, d);
    chk("elem", 32'h80, d);
    got.delete();
    $display("activate test done");
  endtask

  task automatic testPoll;
    // host edits only a host-owned element
    mw(32'h80, 32'h8000_0004);
    for (int i = 0; i < 500 && got.size() < 4; i++)
      @(posedge clk);
    waitState(32'h20);
    chk("repoll", 32'h4433_2211, {got[3], got[2], got[1], got[0]});
    chk("flip", 32'h0000_0004, mr(32'h80));
    chk("quiet", 32'h0, mr(32'h208));
    got.delete();
    $display("poll test done");
  endtask

  task automatic testInhibit;
    logic [31:0] d;
    lat <= 4'h3;
    mw(32'h44, 32'h90);
    mw(32'h90, 32'ha000_0002);
    mw(32'h94, 32'hc4);
    mw(32'h98, 32'ha0);
    mw(32'ha0, 32'h2000_0000);
    mw(32'hc4, 32'h0000_bbaa);
    mw(32'h20c, 32'h0);
    wrReg(CTRL_OFS, 32'h1);
    wrReg(HEAD_OFS, 32'h44);
    wrReg(SREQ_OFS, 32'h1);
    waitState(32'h40);
    chk("count", 32'd2, got.size());
    chk("data", 32'hbbaa, {16'h0, got[1], got[0]});
    chk("kept", 32'ha000_0002, mr(32'h90));
    chk("slot", 32'ha0, mr(32'h20));
    chk("ack", 32'h1000_0000, mr(32'h208));
    chk("noeob", 32'h0, mr(32'h20c));
    rdReg(CTRL_OFS, d);
    chk("ctrl", 32'h1, d);
    $display("inhibit test done");
  endtask

  task automatic testJump;
    logic [31:0] d;
    got.delete();
    wrReg(SREQ_OFS, 32'h2);
    for (int i = 0; i < 500 && got.size() < 2; i++)
      @(posedge clk);
    waitState(32'h40);
    chk("jump", 32'hbbaa, {16'h0, got[1], got[0]});
    chk("jack", 32'h1000_0000, mr(32'h20c));
    rdReg(SREQ_OFS, d);
    chk("pend", 32'h0, d);
    $display("jump test done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    testReset();
    testActivate();
    testPoll();
    testInhibit();
    testJump();
    endOfTest();
  end
endmodule
